// *** verilog/acc_consts.svh ***
// Register addresses, field positions, reset values and counts for the correction block
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

`define ACC_COEF_W 24
`define ACC_OUT_W 16
`define ACC_CMD_BITS 5'h08
`define ACC_DATA_BITS 5'h18
`define ACC_CNT_W 5

`define ACC_CMD_READ_BIT 7
`define ACC_CMD_ADDR_HI 2
`define ACC_CMD_ADDR_LO 0
`define ACC_ADDR_W 3

`define ACC_ADDR_CTRL 3'h0
`define ACC_ADDR_SYS_OFFSET 3'h1
`define ACC_ADDR_SYS_GAIN 3'h2
`define ACC_ADDR_SELF_OFFSET 3'h3
`define ACC_ADDR_DATA 3'h4

`define ACC_CTRL_W 8
`define ACC_CTRL_RESET 8'h1e
`define ACC_CTRL_WMASK 8'hfe
`define ACC_BIT_SYS_GAIN_DIS 4
`define ACC_BIT_SYS_OFFSET_DIS 3
`define ACC_BIT_SELF_OFFSET_DIS 1

`define ACC_COEF_RESET 24'h000000
`define ACC_DATA_RESET 16'h0000

`define ACC_GAIN_FRAC 22
`define ACC_GAIN_ROUND 48'sh000000200000
`define ACC_OUT_SHIFT 8

`endif

// *** verilog/acc_pkg.sv ***
// Types shared by the correction block
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CMD = 2'b01,
        ACC_DATA = 2'b10
    } acc_ser_state_t;

endpackage

// *** verilog/acc_sat_stage.sv ***
// Registered saturating subtract stage with bypass
`timescale 1ns/1ns
`include "acc_consts.svh"

module acc_sat_stage #(
    parameter int W = `ACC_COEF_W
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic inValid, // Input sample valid
    input wire logic signed [W-1:0] a, // Minuend
    input wire logic signed [W-1:0] b, // Subtrahend
    input wire logic subEn, // Subtract when high, else pass
    output logic outValid, // Output sample valid
    output logic signed [W-1:0] y // Saturated result
);

    if (W < 2) begin : g_bad_width
        $error("acc_sat_stage: W too small");
    end

    wire logic signed [W:0] diff;
    wire logic overflow;
    wire logic signed [W-1:0] satVal;
    wire logic signed [W-1:0] next_y;

    assign diff = {a[W-1], a} - {b[W-1], b};
    assign overflow = diff[W] != diff[W-1];
    // Clamp to the code limit on the side of the true sign
    assign satVal = diff[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    assign next_y = !subEn ? a : (overflow ? satVal : diff[W-1:0]);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            outValid <= 1'b0;
            y <= '0;
        end else if (ce) begin
            outValid <= inValid;
            if (inValid) begin
                y <= next_y;
            end
        end
    end

endmodule

// *** verilog/acc_correction.sv ***
// Calibration correction pipeline, output coding and serial coefficient registers
`timescale 1ns/1ns
`include "acc_consts.svh"

module acc_correction #(
    parameter int COEF_W = `ACC_COEF_W,
    parameter int OUT_W = `ACC_OUT_W
) (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic sclk, // Serial clock pin
    input wire logic csB, // Serial chip select pin, active low
    input wire logic din, // Serial data in pin
    output logic dout, // Serial data out
    output logic doutOe, // Serial data out enable
    input wire logic rawValid, // Raw conversion result strobe
    input wire logic signed [COEF_W-1:0] rawData, // Raw conversion result
    input wire logic rangeUnipolar, // Range select, 1 unipolar
    input wire logic formatOffsetBin, // Bipolar output format, 1 offset binary
    input wire logic sysCalLoad, // System calibration result strobe
    input wire logic signed [COEF_W-1:0] sysCalOffset, // Measured system offset
    input wire logic signed [COEF_W-1:0] sysCalGain, // Measured system gain
    input wire logic selfCalLoad, // Self-calibration result strobe
    input wire logic signed [COEF_W-1:0] selfCalOffset, // Measured self offset
    output logic dataValid, // Corrected result strobe
    output logic [OUT_W-1:0] dataOut // Corrected, coded result
);

    if (COEF_W != `ACC_COEF_W || OUT_W != `ACC_OUT_W) begin : g_bad_width
        $error("acc_correction: only 24-bit coefficients and 16-bit output supported");
    end

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    logic sclkQ1, sclkQ2, sclkQ3;
    logic csQ1, csQ2;
    logic dinQ1, dinQ2;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sclkQ1 <= 1'b0;
            sclkQ2 <= 1'b0;
            sclkQ3 <= 1'b0;
            csQ1 <= 1'b1;
            csQ2 <= 1'b1;
            dinQ1 <= 1'b0;
            dinQ2 <= 1'b0;
        end else if (ce) begin
            sclkQ1 <= sclk;
            sclkQ2 <= sclkQ1;
            sclkQ3 <= sclkQ2;
            csQ1 <= csB;
            csQ2 <= csQ1;
            dinQ1 <= din;
            dinQ2 <= dinQ1;
        end
    end

    wire logic sclkRise;
    wire logic sclkFall;
    wire logic selected;

    assign sclkRise = sclkQ2 && !sclkQ3;
    assign sclkFall = !sclkQ2 && sclkQ3;
    assign selected = !csQ2;

    // =====================================================================
    // Serial frame: 8-bit command then 24 data bits, MSB first
    // =====================================================================
    acc_pkg::acc_ser_state_t serState;
    acc_pkg::acc_ser_state_t next_serState;
    logic [`ACC_CNT_W-1:0] bitCnt;
    logic [`ACC_CMD_BITS-1:0] cmdShift;
    logic [COEF_W-1:0] inShift;
    logic [COEF_W-1:0] outShift;
    logic isRead;
    logic [`ACC_ADDR_W-1:0] addr;

    wire logic [`ACC_CMD_BITS-1:0] cmdNext;
    wire logic [COEF_W-1:0] inNext;
    wire logic cmdDone;
    wire logic dataDone;
    wire logic [`ACC_ADDR_W-1:0] cmdAddr;
    wire logic hostWr;

    assign cmdNext = {cmdShift[`ACC_CMD_BITS-2:0], dinQ2};
    assign inNext = {inShift[COEF_W-2:0], dinQ2};
    assign cmdDone = (serState == acc_pkg::ACC_CMD) && sclkRise
        && (bitCnt == `ACC_CMD_BITS - 5'h01);
    assign dataDone = (serState == acc_pkg::ACC_DATA) && sclkRise
        && (bitCnt == `ACC_DATA_BITS - 5'h01);
    assign cmdAddr = cmdNext[`ACC_CMD_ADDR_HI:`ACC_CMD_ADDR_LO];
    assign hostWr = dataDone && !isRead;

    always_comb begin
        next_serState = serState;
        case (serState)
            acc_pkg::ACC_IDLE: begin
                if (selected) begin
                    next_serState = acc_pkg::ACC_CMD;
                end
            end
            acc_pkg::ACC_CMD: begin
                if (!selected) begin
                    next_serState = acc_pkg::ACC_IDLE;
                end else if (cmdDone) begin
                    next_serState = acc_pkg::ACC_DATA;
                end
            end
            acc_pkg::ACC_DATA: begin
                if (!selected || dataDone) begin
                    next_serState = acc_pkg::ACC_IDLE;
                end
            end
            default: begin
                next_serState = acc_pkg::ACC_IDLE;
            end
        endcase
    end

    // Frame ends after one word; a new word needs chip select to drop again
    logic frameUsed;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            serState <= acc_pkg::ACC_IDLE;
            frameUsed <= 1'b0;
        end else if (ce) begin
            if (serState == acc_pkg::ACC_IDLE && frameUsed) begin
                serState <= acc_pkg::ACC_IDLE;
            end else begin
                serState <= next_serState;
            end
            frameUsed <= selected && (frameUsed || dataDone);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt <= '0;
            cmdShift <= '0;
            inShift <= '0;
        end else if (ce) begin
            if (serState == acc_pkg::ACC_IDLE || cmdDone) begin
                bitCnt <= '0;
            end else if (sclkRise) begin
                bitCnt <= bitCnt + 5'h01;
            end
            if (serState == acc_pkg::ACC_CMD && sclkRise) begin
                cmdShift <= cmdNext;
            end
            if (serState == acc_pkg::ACC_DATA && sclkRise) begin
                inShift <= inNext;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            isRead <= 1'b0;
            addr <= '0;
        end else if (ce && cmdDone) begin
            isRead <= cmdNext[`ACC_CMD_READ_BIT];
            addr <= cmdAddr;
        end
    end

    // =====================================================================
    // Coefficient and control registers
    // =====================================================================
    logic [`ACC_CTRL_W-1:0] calibration_control_register;
    logic signed [COEF_W-1:0] system_offset_coefficient;
    logic signed [COEF_W-1:0] system_gain_coefficient;
    logic signed [COEF_W-1:0] self_cal_offset_coefficient;

    wire logic system_offset_disable;
    wire logic system_gain_disable;
    wire logic self_cal_offset_disable;
    wire logic [`ACC_CTRL_W-1:0] ctrlWr;

    assign system_offset_disable = calibration_control_register[`ACC_BIT_SYS_OFFSET_DIS];
    assign system_gain_disable = calibration_control_register[`ACC_BIT_SYS_GAIN_DIS];
    assign self_cal_offset_disable = calibration_control_register[`ACC_BIT_SELF_OFFSET_DIS];
    assign ctrlWr = inNext[`ACC_CTRL_W-1:0] & `ACC_CTRL_WMASK;

    // Measured values take priority over a host write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            calibration_control_register <= `ACC_CTRL_RESET;
            system_offset_coefficient <= `ACC_COEF_RESET;
            system_gain_coefficient <= `ACC_COEF_RESET;
            self_cal_offset_coefficient <= `ACC_COEF_RESET;
        end else if (ce) begin
            if (hostWr && addr == `ACC_ADDR_CTRL) begin
                calibration_control_register <= ctrlWr;
            end
            if (sysCalLoad) begin
                system_offset_coefficient <= sysCalOffset;
                system_gain_coefficient <= sysCalGain;
            end else begin
                if (hostWr && addr == `ACC_ADDR_SYS_OFFSET) begin
                    system_offset_coefficient <= inNext;
                end
                if (hostWr && addr == `ACC_ADDR_SYS_GAIN) begin
                    system_gain_coefficient <= inNext;
                end
            end
            if (selfCalLoad) begin
                self_cal_offset_coefficient <= selfCalOffset;
            end else if (hostWr && addr == `ACC_ADDR_SELF_OFFSET) begin
                self_cal_offset_coefficient <= inNext;
            end
        end
    end

    // =====================================================================
    // Read-back path
    // =====================================================================
    logic [COEF_W-1:0] readVal;

    always_comb begin
        case (cmdAddr)
            `ACC_ADDR_CTRL: begin
                readVal = {{(COEF_W-`ACC_CTRL_W){1'b0}}, calibration_control_register};
            end
            `ACC_ADDR_SYS_OFFSET: readVal = system_offset_coefficient;
            `ACC_ADDR_SYS_GAIN: readVal = system_gain_coefficient;
            `ACC_ADDR_SELF_OFFSET: readVal = self_cal_offset_coefficient;
            `ACC_ADDR_DATA: readVal = {dataOut, {`ACC_OUT_SHIFT{1'b0}}};
            default: readVal = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            outShift <= '0;
            dout <= 1'b0;
            doutOe <= 1'b0;
        end else if (ce) begin
            doutOe <= selected;
            if (cmdDone) begin
                outShift <= readVal;
            end else if (serState == acc_pkg::ACC_DATA && isRead && sclkFall) begin
                dout <= outShift[COEF_W-1];
                outShift <= {outShift[COEF_W-2:0], 1'b0};
            end
        end
    end

    // =====================================================================
    // Correction pipeline
    // =====================================================================
    wire logic s1Valid;
    wire logic signed [COEF_W-1:0] s1Data;
    wire logic s2Valid;
    wire logic signed [COEF_W-1:0] s2Data;

    // First correction: self-calibration offset
    acc_sat_stage #(.W(COEF_W)) u_self_offset (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .inValid(rawValid),
        .a(rawData),
        .b(self_cal_offset_coefficient),
        .subEn(!self_cal_offset_disable),
        .outValid(s1Valid),
        .y(s1Data)
    );

    // Second correction: system offset, ahead of gain and range scale
    acc_sat_stage #(.W(COEF_W)) u_sys_offset (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .inValid(s1Valid),
        .a(s1Data),
        .b(system_offset_coefficient),
        .subEn(!system_offset_disable),
        .outValid(s2Valid),
        .y(s2Data)
    );

    // Gain: coefficient is signed with 22 fraction bits, so 0x7fffff is near 2x
    wire logic signed [2*COEF_W-1:0] product;
    wire logic signed [2*COEF_W-1:0] rounded;
    wire logic signed [2*COEF_W-1:0] shifted;
    wire logic gainOvf;
    wire logic signed [COEF_W-1:0] gainSat;
    wire logic signed [COEF_W-1:0] next_gained;
    logic s3Valid;
    logic signed [COEF_W-1:0] gained;

    assign product = s2Data * system_gain_coefficient;
    assign rounded = product + `ACC_GAIN_ROUND;
    assign shifted = rounded >>> `ACC_GAIN_FRAC;
    assign gainOvf = !((&shifted[2*COEF_W-1:COEF_W-1]) || !(|shifted[2*COEF_W-1:COEF_W-1]));
    assign gainSat = shifted[2*COEF_W-1] ? {1'b1, {(COEF_W-1){1'b0}}}
        : {1'b0, {(COEF_W-1){1'b1}}};
    assign next_gained = system_gain_disable ? s2Data
        : (gainOvf ? gainSat : shifted[COEF_W-1:0]);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s3Valid <= 1'b0;
            gained <= '0;
        end else if (ce) begin
            s3Valid <= s2Valid;
            if (s2Valid) begin
                gained <= next_gained;
            end
        end
    end

    // =====================================================================
    // Range scale and output coding
    // =====================================================================
    wire logic uniNeg;
    wire logic uniOvf;
    wire logic [COEF_W-1:0] uniScaled;
    wire logic [OUT_W-1:0] uniCode;
    wire logic [OUT_W-1:0] bipTwos;
    wire logic [OUT_W-1:0] bipOffset;
    wire logic [OUT_W-1:0] next_dataOut;

    assign uniNeg = gained[COEF_W-1];
    assign uniOvf = gained[COEF_W-2];
    // Unipolar doubles the corrected value, clamped to 0 and full scale
    assign uniScaled = uniNeg ? '0 : (uniOvf ? '1 : {gained[COEF_W-2:0], 1'b0});
    assign uniCode = uniScaled[COEF_W-1:`ACC_OUT_SHIFT];
    assign bipTwos = gained[COEF_W-1:`ACC_OUT_SHIFT];
    assign bipOffset = {~bipTwos[OUT_W-1], bipTwos[OUT_W-2:0]};
    assign next_dataOut = rangeUnipolar ? uniCode
        : (formatOffsetBin ? bipOffset : bipTwos);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dataValid <= 1'b0;
            dataOut <= `ACC_DATA_RESET;
        end else if (ce) begin
            dataValid <= s3Valid;
            if (s3Valid) begin
                dataOut <= next_dataOut;
            end
        end
    end

endmodule

// *** sim/acc_correction_properties.sv ***
// Port-level assertions for the correction block
`timescale 1ns/1ns
module acc_correction_properties #(
    parameter int COEF_W = 24,
    parameter int OUT_W = 16
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic sclk, // Serial clock pin
    input wire logic csB, // Chip select, active low
    input wire logic dout, // Serial data out
    input wire logic doutOe, // Data out enable
    input wire logic rawValid, // Raw sample strobe
    input wire logic dataValid, // Result strobe
    input wire logic [OUT_W-1:0] dataOut // Result code
);
    // ====================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_valid_latency: assert property (rawValid |-> ##4 dataValid)
        else $error("result strobe missing four cycles after a sample");
    chk_valid_cause: assert property (dataValid |-> $past(rawValid, 4))
        else $error("result strobe without a sample four cycles before");
    chk_result_hold: assert property (!dataValid |-> $stable(dataOut))
        else $error("result code changed without a strobe");
    chk_oe_rise: assert property ($fell(csB) |-> ##[2:6] doutOe)
        else $error("data out not enabled after select");
    chk_oe_fall: assert property ($rose(csB) |-> ##[2:6] !doutOe)
        else $error("data out still enabled after deselect");
    chk_oe_idle: assert property (csB [*6] |-> !doutOe)
        else $error("data out enabled while deselected");
    chk_oe_frame: assert property (!csB [*6] |-> doutOe)
        else $error("data out disabled inside a frame");
    chk_dout_edge: assert property ($changed(dout) && doutOe && $past(doutOe) |-> !sclk)
        else $error("data out moved while serial clock high");

    cover property (rawValid ##1 rawValid);
    cover property ($fell(csB) ##[1:20] doutOe);
    cover property (dataValid && dataOut == 16'hffff);
endmodule

bind acc_correction acc_correction_properties #(.COEF_W(COEF_W), .OUT_W(OUT_W)) u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .csB(csB), .dout(dout),
    .doutOe(doutOe), .rawValid(rawValid), .dataValid(dataValid), .dataOut(dataOut));

// *** sim/acc_host_model.sv ***
// Host model driving the serial register port
`timescale 1ns/1ns
module acc_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk_sys, // System clock
    output logic sclk, // Serial clock pin
    output logic csB, // Chip select, active low
    output logic din, // Serial data to device
    input wire logic dout, // Serial data from device
    input wire logic doutOe // Device drives data out
);
    initial begin
        sclk = 1'b0;
        csB = 1'b1;
        din = 1'b0;
    end

    // Idle data line carries no meaning
    always @(negedge clk_sys) begin
        if (csB) begin
            din <= ~din;
        end
    end

    // ====================================
    // One frame; fewer than 32 bits aborts it
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wr, input int nbits,
                        output logic [23:0] rd);
        logic [31:0] frame;
        frame = {cmd, wr};
        rd = 24'h000000;
        csB = 1'b0;
        repeat (HALF) @(negedge clk_sys);
        for (int i = 31; i > 31 - nbits; i--) begin
            din = frame[i];
            repeat (HALF) @(negedge clk_sys);
            if (i < 24 && doutOe === 1'b1) begin
                rd[i] = dout;
            end
            sclk = 1'b1;
            repeat (HALF) @(negedge clk_sys);
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk_sys);
        csB = 1'b1;
        repeat (HALF) @(negedge clk_sys);
    endtask
endmodule

// *** sim/acc_correction_tb_top.sv ***
// Self-checking bench for the correction block
`timescale 1ns/1ns
module acc_correction_tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic sclk, csB, din, dout, doutOe, dataValid;
    logic rawValid = 1'b0;
    logic ce = 1'b1;
    logic rangeUnipolar = 1'b0;
    logic formatOffsetBin = 1'b0;
    logic sysCalLoad = 1'b0;
    logic selfCalLoad = 1'b0;
    logic signed [23:0] rawData = 24'sh000000;
    logic signed [23:0] sysCalOffset = 24'sh000000;
    logic signed [23:0] sysCalGain = 24'sh000000;
    logic signed [23:0] selfCalOffset = 24'sh000000;
    logic signed [23:0] sco = 24'sh000000;
    logic signed [23:0] so = 24'sh000000;
    logic signed [23:0] sg = 24'sh000000;
    logic [15:0] dataOut;
    logic [15:0] lastOut = 16'h0000;
    logic [7:0] ctl = 8'h1e;
    logic [7:0] cfg [5] = '{8'h1e, 8'h00, 8'h16, 8'h1c, 8'h0e};
    logic [23:0] rd;
    logic [15:0] expQ[$];
    int num_errors = 0;
    int comparisons = 0;
    int seed = 32'h592a14f3;

    always #2 clk_sys = ~clk_sys;

    acc_correction dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .sclk(sclk), .csB(csB), .din(din),
        .dout(dout), .doutOe(doutOe), .rawValid(rawValid), .rawData(rawData),
        .rangeUnipolar(rangeUnipolar), .formatOffsetBin(formatOffsetBin),
        .sysCalLoad(sysCalLoad), .sysCalOffset(sysCalOffset), .sysCalGain(sysCalGain),
        .selfCalLoad(selfCalLoad), .selfCalOffset(selfCalOffset),
        .dataValid(dataValid), .dataOut(dataOut));

    acc_host_model #(.HALF(8)) host (
        .clk_sys(clk_sys), .sclk(sclk), .csB(csB), .din(din), .dout(dout), .doutOe(doutOe));

    // ====================================
    // Expected values
    function automatic logic signed [49:0] sat(input logic signed [49:0] v);
        sat = (v > 50'sh7fffff) ? 50'sh7fffff : (v < -50'sh800000) ? -50'sh800000 : v;
    endfunction

    function automatic logic [15:0] code(input logic signed [23:0] raw);
        logic signed [49:0] x;
        x = raw;
        if (!ctl[1]) x = sat(x - sco);
        if (!ctl[3]) x = sat(x - so);
        if (!ctl[4]) x = sat((x * sg + 50'sh200000) >>> 22);
        if (rangeUnipolar) code = (x < 0) ? 16'h0000 : (x > 50'sh3fffff) ? 16'hffff : x[22:7];
        else code = {x[23] ^ formatOffsetBin, x[22:8]};
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [23:0] d);
        host.xfer({5'h00, a}, d, 32, rd);
    endtask

    task automatic reg_chk(input logic [2:0] a, input logic [23:0] e);
        host.xfer({5'h10, a}, 24'h000000, 32, rd);
        check(rd, e);
    endtask

    // Back-to-back samples, corner codes first
    task automatic run_burst();
        logic signed [23:0] r;
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 24'sh7fffff : (i == 1) ? 24'sh800000 : 24'sh000000;
            if (i > 2) r = 24'($random(seed));
            rawData <= r;
            rawValid <= 1'b1;
            lastOut = code(r);
            expQ.push_back(lastOut);
            @(negedge clk_sys);
        end
        rawValid <= 1'b0;
        for (int t = 0; t < 20 && expQ.size() > 0; t++) @(negedge clk_sys);
        if (expQ.size() != 0) begin
            num_errors++;
            stop_test();
        end
    endtask

    always @(negedge clk_sys) begin
        if (rst_b && dataValid === 1'b1) begin
            check({8'h00, dataOut}, {8'h00, (expQ.size() > 0) ? expQ.pop_front() : 16'hxxxx});
        end
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end

    // ====================================
    // Main sequence
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        for (int a = 0; a < 8; a++) reg_chk(a[2:0], (a == 0) ? 24'h00001e : 24'h000000);
        reg_wr(3'h4, 24'h123456);
        reg_wr(3'h6, 24'h654321);
        reg_chk(3'h4, 24'h000000);
        reg_chk(3'h6, 24'h000000);
        reg_wr(3'h0, 24'h0000ff);
        reg_chk(3'h0, 24'h0000fe);
        so = 24'($random(seed) >>> 12);
        sg = 24'sh200000 + 24'($random(seed) & 32'h003fffff);
        sco = 24'($random(seed) >>> 12);
        reg_wr(3'h1, so);
        reg_wr(3'h2, sg);
        reg_wr(3'h3, sco);
        reg_chk(3'h1, so);
        reg_chk(3'h2, sg);
        reg_chk(3'h3, sco);
        host.xfer(8'h01, ~so, 20, rd);
        reg_chk(3'h1, so);
        for (int c = 0; c < 15; c++) begin
            ctl = cfg[c / 3];
            reg_wr(3'h0, {16'h0000, ctl});
            rangeUnipolar <= (c % 3 == 2);
            formatOffsetBin <= (c % 3 == 1);
            @(negedge clk_sys);
            run_burst();
        end
        reg_chk(3'h4, {lastOut, 8'h00});
        // Enable low must swallow a calibration load
        ce <= 1'b0;
        sysCalLoad <= 1'b1;
        sysCalOffset <= ~so;
        @(negedge clk_sys);
        sysCalLoad <= 1'b0;
        ce <= 1'b1;
        @(negedge clk_sys);
        reg_chk(3'h1, so);
        sysCalOffset <= 24'($random(seed) >>> 12);
        sysCalGain <= 24'sh7fffff;
        selfCalOffset <= 24'($random(seed) >>> 12);
        sysCalLoad <= 1'b1;
        selfCalLoad <= 1'b1;
        @(negedge clk_sys);
        sysCalLoad <= 1'b0;
        selfCalLoad <= 1'b0;
        so = sysCalOffset;
        sg = sysCalGain;
        sco = selfCalOffset;
        reg_chk(3'h1, so);
        reg_chk(3'h2, sg);
        reg_chk(3'h3, sco);
        ctl = 8'h00;
        reg_wr(3'h0, 24'h000000);
        rangeUnipolar <= 1'b0;
        formatOffsetBin <= 1'b0;
        @(negedge clk_sys);
        run_burst();
        rst_b = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        reg_chk(3'h0, 24'h00001e);
        reg_chk(3'h2, 24'h000000);
        stop_test();
    end
endmodule
